// >>> aod_defs.vh
`ifndef AOD_DEFS_VH
`define AOD_DEFS_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define AOD_SAMPLE_W     12
`define AOD_MAG_W        11
`define AOD_CMP_W        8
`define AOD_CMP_LSB      3
`define AOD_SEL_W        3
`define AOD_CNT_W        11
`define AOD_NUM_CH       4
`define AOD_ADDR_W       4
`define AOD_DATA_W       32

// ----------------------------------------------------------------------------
// Magnitude limits
// ----------------------------------------------------------------------------
`define AOD_MAG_MAX      11'h7ff
`define AOD_SAMPLE_MIN   12'h800

// ----------------------------------------------------------------------------
// Pulse length base: 8 cycles shifted left by the select value
// ----------------------------------------------------------------------------
`define AOD_PULSE_BASE   11'h008

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define AOD_REG_CTRL     4'h0
`define AOD_REG_THRESH   4'h4
`define AOD_REG_STATUS   4'h8
`define AOD_REG_MASK     4'hc

// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define AOD_CTRL_EN_BIT  0
`define AOD_CTRL_SEL_LSB 4
`define AOD_CTRL_SEL_MSB 6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AOD_RST_THRESH   8'he4
`define AOD_RST_SEL      3'h0
`define AOD_RST_MASK     4'h0

`endif

// >>> aod_gain_model.sv
`default_nettype none
// -----------------------------------------------
// Gain logic stand-in: notes which pins fired
// -----------------------------------------------
module aod_gain_model (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] flags_i,
    output var  logic [3:0] seen_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // One sticky bit per dedicated flag pin
    always_ff @(posedge core_clk_i) seen_o <= rst_i ? 4'h0 : (seen_o | flags_i);
endmodule
`default_nettype wire

// >>> aod_overrange_detector.v
// Notes on behaviour
// - Samples are signed, -2048 to +2047
// - Samples taken on rising sampling clock edge
// - Compare upper 8 of 11-bit magnitude
// - Most negative sample saturates to 2047
// - One threshold shared by all channels
// - Disabled detector produces no flags
// - Flag set when magnitude bits reach threshold
// - One dedicated flag pin per channel
// - Hold flag 8 times 2^n cycles
`include "aod_defs.vh"
`default_nettype none

module aod_overrange_detector (
    input  wire                        core_clk_i,
    input  wire                        rst_i,
    input  wire [`AOD_SAMPLE_W-1:0]    sample_a_i,
    input  wire [`AOD_SAMPLE_W-1:0]    sample_b_i,
    input  wire [`AOD_SAMPLE_W-1:0]    sample_c_i,
    input  wire [`AOD_SAMPLE_W-1:0]    sample_d_i,
    input  wire [`AOD_ADDR_W-1:0]      reg_addr_i,
    input  wire [`AOD_DATA_W-1:0]      reg_wdata_i,
    input  wire                        reg_wr_i,
    input  wire                        reg_rd_i,
    output reg  [`AOD_DATA_W-1:0]      reg_rdata_o,
    output reg                         overrange_flag_a_o,
    output reg                         overrange_flag_b_o,
    output reg                         overrange_flag_c_o,
    output reg                         overrange_flag_d_o,
    output reg                         irq_o
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Magnitude of a two's-complement sample, saturating at the bottom code
    function [`AOD_MAG_W-1:0] aod_mag;
        input [`AOD_SAMPLE_W-1:0] s;
        reg   [`AOD_SAMPLE_W-1:0] neg;
        begin
            neg = ~s + {{(`AOD_SAMPLE_W-1){1'b0}}, 1'b1};
            if (s == `AOD_SAMPLE_MIN) begin
                aod_mag = `AOD_MAG_MAX;
            end else if (s[`AOD_SAMPLE_W-1]) begin
                aod_mag = neg[`AOD_MAG_W-1:0];
            end else begin
                aod_mag = s[`AOD_MAG_W-1:0];
            end
        end
    endfunction

    // Upper magnitude bits against the shared threshold
    function aod_over;
        input [`AOD_SAMPLE_W-1:0] s;
        input [`AOD_CMP_W-1:0]    th;
        reg   [`AOD_MAG_W-1:0]    m;
        begin
            m        = aod_mag(s);
            aod_over = (m[`AOD_MAG_W-1:`AOD_CMP_LSB] >= th);
        end
    endfunction

    // Count value minus one, used for reload and countdown
    function [`AOD_CNT_W-1:0] aod_dec;
        input [`AOD_CNT_W-1:0] v;
        begin
            aod_dec = v - {{(`AOD_CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg                     overrange_enable;
    reg [`AOD_CMP_W-1:0]    overrange_threshold;
    reg [`AOD_SEL_W-1:0]    overrange_pulse_length_sel;
    reg [`AOD_NUM_CH-1:0]   irq_status;
    reg [`AOD_NUM_CH-1:0]   irq_mask;

    reg [`AOD_SAMPLE_W-1:0] smp [0:`AOD_NUM_CH-1];
    reg [`AOD_CNT_W-1:0]    hold_cnt [0:`AOD_NUM_CH-1];
    reg [`AOD_NUM_CH-1:0]   hit;
    reg [`AOD_NUM_CH-1:0]   flag;

    wire [`AOD_CNT_W-1:0]   pulse_len;
    wire                    wr_ctrl;
    wire                    wr_thresh;
    wire                    wr_status;
    wire                    wr_mask;
    wire                    irq_pending;
    integer                 ch_hit;
    integer                 ch_hold;

    assign pulse_len = `AOD_PULSE_BASE << overrange_pulse_length_sel;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------

    // One write select per register
    assign wr_ctrl   = reg_wr_i && (reg_addr_i == `AOD_REG_CTRL);
    assign wr_thresh = reg_wr_i && (reg_addr_i == `AOD_REG_THRESH);
    assign wr_status = reg_wr_i && (reg_addr_i == `AOD_REG_STATUS);
    assign wr_mask   = reg_wr_i && (reg_addr_i == `AOD_REG_MASK);

    // Any status bit that software lets through
    assign irq_pending = |(irq_status & irq_mask);

    // ------------------------------------------------------------------------
    // Sample capture
    // ------------------------------------------------------------------------

    // Channel a sample, taken on the rising sampling edge
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            smp[0] <= {`AOD_SAMPLE_W{1'b0}};
        end else begin
            smp[0] <= sample_a_i;
        end
    end

    // Channel b sample
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            smp[1] <= {`AOD_SAMPLE_W{1'b0}};
        end else begin
            smp[1] <= sample_b_i;
        end
    end

    // Channel c sample
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            smp[2] <= {`AOD_SAMPLE_W{1'b0}};
        end else begin
            smp[2] <= sample_c_i;
        end
    end

    // Channel d sample
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            smp[3] <= {`AOD_SAMPLE_W{1'b0}};
        end else begin
            smp[3] <= sample_d_i;
        end
    end

    // ------------------------------------------------------------------------
    // Detection
    // ------------------------------------------------------------------------

    // Per-channel hit, gated by enable, same threshold for all
    always @* begin
        for (ch_hit = 0; ch_hit < `AOD_NUM_CH; ch_hit = ch_hit + 1) begin
            hit[ch_hit] = overrange_enable &&
                          aod_over(smp[ch_hit], overrange_threshold);
        end
    end

    // Hold counters: a hit reloads the full pulse length
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            for (ch_hold = 0; ch_hold < `AOD_NUM_CH; ch_hold = ch_hold + 1) begin
                hold_cnt[ch_hold] <= {`AOD_CNT_W{1'b0}};
                flag[ch_hold]     <= 1'b0;
            end
        end else begin
            for (ch_hold = 0; ch_hold < `AOD_NUM_CH; ch_hold = ch_hold + 1) begin
                if (!overrange_enable) begin
                    hold_cnt[ch_hold] <= {`AOD_CNT_W{1'b0}};
                    flag[ch_hold]     <= 1'b0;
                end else if (hit[ch_hold]) begin
                    hold_cnt[ch_hold] <= aod_dec(pulse_len);
                    flag[ch_hold]     <= 1'b1;
                end else if (hold_cnt[ch_hold] != {`AOD_CNT_W{1'b0}}) begin
                    hold_cnt[ch_hold] <= aod_dec(hold_cnt[ch_hold]);
                    flag[ch_hold]     <= 1'b1;
                end else begin
                    flag[ch_hold]     <= 1'b0;
                end
            end
        end
    end

    // Flag pin for channel a
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            overrange_flag_a_o <= 1'b0;
        end else begin
            overrange_flag_a_o <= flag[0];
        end
    end

    // Flag pin for channel b
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            overrange_flag_b_o <= 1'b0;
        end else begin
            overrange_flag_b_o <= flag[1];
        end
    end

    // Flag pin for channel c
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            overrange_flag_c_o <= 1'b0;
        end else begin
            overrange_flag_c_o <= flag[2];
        end
    end

    // Flag pin for channel d
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            overrange_flag_d_o <= 1'b0;
        end else begin
            overrange_flag_d_o <= flag[3];
        end
    end

    // ------------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------------

    // Control: enable and pulse length select
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            overrange_enable           <= 1'b0;
            overrange_pulse_length_sel <= `AOD_RST_SEL;
        end else if (wr_ctrl) begin
            overrange_enable           <= reg_wdata_i[`AOD_CTRL_EN_BIT];
            overrange_pulse_length_sel <= reg_wdata_i[`AOD_CTRL_SEL_MSB:`AOD_CTRL_SEL_LSB];
        end
    end

    // Shared threshold for every channel
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            overrange_threshold <= `AOD_RST_THRESH;
        end else if (wr_thresh) begin
            overrange_threshold <= reg_wdata_i[`AOD_CMP_W-1:0];
        end
    end

    // Interrupt mask, same layout as status
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_mask <= `AOD_RST_MASK;
        end else if (wr_mask) begin
            irq_mask <= reg_wdata_i[`AOD_NUM_CH-1:0];
        end
    end

    // Sticky status; a new event wins over a clear
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_status <= {`AOD_NUM_CH{1'b0}};
        end else if (wr_status) begin
            irq_status <= (irq_status & ~reg_wdata_i[`AOD_NUM_CH-1:0]) | hit;
        end else begin
            irq_status <= irq_status | hit;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= {`AOD_DATA_W{1'b0}};
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `AOD_REG_CTRL: begin
                    reg_rdata_o <= {{(`AOD_DATA_W-`AOD_CTRL_SEL_MSB-1){1'b0}},
                                    overrange_pulse_length_sel, 3'h0, overrange_enable};
                end
                `AOD_REG_THRESH: begin
                    reg_rdata_o <= {{(`AOD_DATA_W-`AOD_CMP_W){1'b0}}, overrange_threshold};
                end
                `AOD_REG_STATUS: begin
                    reg_rdata_o <= {{(`AOD_DATA_W-`AOD_NUM_CH){1'b0}}, irq_status};
                end
                `AOD_REG_MASK: begin
                    reg_rdata_o <= {{(`AOD_DATA_W-`AOD_NUM_CH){1'b0}}, irq_mask};
                end
                default: begin
                    reg_rdata_o <= {`AOD_DATA_W{1'b0}};
                end
            endcase
        end else begin
            reg_rdata_o <= {`AOD_DATA_W{1'b0}};
        end
    end

    // Interrupt level from unmasked status
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_pending;
        end
    end

endmodule

`default_nettype wire

// >>> aod_overrange_detector_props.sv
`default_nettype none
// -----------------------------------------------
// Port checker for the over-range detector
// -----------------------------------------------
module aod_overrange_detector_props (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic [11:0] sample_a_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        overrange_flag_a_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        en_s;
    logic [2:0]  sel_s;
    logic [7:0]  th_s;
    logic [3:0]  mk_s;
    logic [11:0] since;
    logic [10:0] mag;
    wire         hit = en_s && (mag[10:3] >= th_s);
    // Magnitude with the most negative code pinned at full scale
    always_comb mag = (sample_a_i == 12'h800) ? 11'h7ff :
        (sample_a_i[11] ? 11'(-sample_a_i) : sample_a_i[10:0]);
    // Shadow settings and cycles since the last hit
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            en_s <= 1'b0;
            sel_s <= 3'h0;
            th_s <= 8'he4;
            mk_s <= 4'h0;
            since <= 12'hfff;
        end else begin
            if (reg_wr_i && reg_addr_i == 4'h0) begin
                en_s <= reg_wdata_i[0];
                sel_s <= reg_wdata_i[6:4];
            end
            if (reg_wr_i && reg_addr_i == 4'h4) th_s <= reg_wdata_i[7:0];
            if (reg_wr_i && reg_addr_i == 4'hc) mk_s <= reg_wdata_i[3:0];
            if (hit) since <= 12'h000;
            else if (since != 12'hfff) since <= since + 12'h001;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    property p_hit_a; (hit && !reg_wr_i) ##1 !reg_wr_i |=> ##1 overrange_flag_a_o; endproperty
    a_hit_a: assert property (p_hit_a) else $error("flag a missing after hit");
    property p_rise_a; $rose(overrange_flag_a_o) |-> since == 12'h002; endproperty
    a_rise_a: assert property (p_rise_a) else $error("flag a rose without hit");
    property p_fall_a;
        $fell(overrange_flag_a_o) && en_s |-> since == (12'h008 << sel_s) + 12'h002;
    endproperty
    a_fall_a: assert property (p_fall_a) else $error("flag a hold length wrong");
    property p_dis_a; !en_s [*2] |=> !overrange_flag_a_o; endproperty
    a_dis_a: assert property (p_dis_a) else $error("flag a while disabled");
    property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_rd_th; reg_rd_i && reg_addr_i == 4'h4 |=> reg_rdata_o == {24'h0, th_s}; endproperty
    a_rd_th: assert property (p_rd_th) else $error("threshold readback wrong");
    property p_irq_off; (mk_s == 4'h0) [*2] |-> !irq_o; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
    property p_irq_on; (hit && mk_s[0] && !reg_wr_i) ##1 !reg_wr_i [*2] |=> irq_o; endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing after hit");
    cover property (hit);
    cover property ($fell(overrange_flag_a_o));
    cover property (irq_o);
endmodule
bind aod_overrange_detector aod_overrange_detector_props u_props (.core_clk_i, .rst_i,
    .sample_a_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .overrange_flag_a_o, .irq_o);
`default_nettype wire

// >>> aod_overrange_detector_tb.sv
`default_nettype none
module aod_overrange_detector_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [11:0] smp [4] = '{default: 12'h000};
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    wire  [31:0] rdata;
    wire  [3:0]  flag;
    wire         irq;
    wire  [3:0]  seen;
    int          bad_count = 0;
    int          checks = 0;
    int          n;
    always #25 core_clk_i = ~core_clk_i;
    aod_overrange_detector dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .sample_a_i(smp[0]),
        .sample_b_i(smp[1]), .sample_c_i(smp[2]), .sample_d_i(smp[3]), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .overrange_flag_a_o(flag[0]), .overrange_flag_b_o(flag[1]),
        .overrange_flag_c_o(flag[2]), .overrange_flag_d_o(flag[3]), .irq_o(irq));
    aod_gain_model far (.core_clk_i(core_clk_i), .rst_i(rst_i), .flags_i(flag), .seen_o(seen));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // One-cycle sample, optional second one after gap, while counting flag cycles over a fixed 1100-cycle window
    task automatic pulse(input int ch, input logic [11:0] v, input int gap, input int len);
        n = 0;
        fork
            repeat (1100) begin
                @(posedge core_clk_i);
                #1 if (flag[ch] !== 1'b0) n++;
            end
            begin
                @(posedge core_clk_i);
                smp[ch] <= v;
                @(posedge core_clk_i);
                smp[ch] <= 12'h000;
                repeat (gap) @(posedge core_clk_i);
                if (gap > 0) smp[ch] <= v;
                @(posedge core_clk_i);
                smp[ch] <= 12'h000;
            end
        join
        chk(32'(n), 32'(len));
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd_reg(4'h0, 32'h0);
        rd_reg(4'h4, 32'he4);
        rd_reg(4'h2, 32'h0);
        pulse(0, 12'h7ff, 0, 0);
        wr_reg(4'h0, 32'h1);
        rd_reg(4'h0, 32'h1);
        pulse(0, 12'h71f, 0, 0);
        pulse(1, 12'h8e1, 0, 0);
        pulse(2, 12'h720, 0, 8);
        pulse(3, 12'h8e0, 0, 8);
        pulse(0, 12'h800, 0, 8);
        pulse(1, 12'h800, 5, 14);
        for (int s = 0; s < 8; s++) begin
            wr_reg(4'h0, 32'((s << 4) | 1));
            rd_reg(4'h0, 32'((s << 4) | 1));
            pulse(s % 4, 12'h7ff, 0, 8 << s);
        end
        wr_reg(4'h0, 32'h1);
        wr_reg(4'h4, 32'h10);
        pulse(2, 12'h080, 0, 8);
        pulse(3, 12'hf81, 0, 0);
        wr_reg(4'h8, 32'hf);
        wr_reg(4'hc, 32'h1);
        rd_reg(4'hc, 32'h1);
        rd_reg(4'h8, 32'h0);
        chk({31'h0, irq}, 32'h0);
        pulse(1, 12'h800, 0, 8);
        rd_reg(4'h8, 32'h2);
        chk({31'h0, irq}, 32'h0);
        pulse(0, 12'h800, 0, 8);
        rd_reg(4'h8, 32'h3);
        chk({31'h0, irq}, 32'h1);
        wr_reg(4'hc, 32'h0);
        rd_reg(4'h8, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr_reg(4'h8, 32'h3);
        rd_reg(4'h8, 32'h0);
        chk({28'h0, seen}, 32'hf);
        wrap_up();
    end
endmodule
`default_nettype wire
